// ---- src/csp_pkg.sv ----
// shared constants for the control and status page register bank
package csp_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h05;
    localparam logic [7:0] IDX_CONTROL = 8'h09;
    localparam logic [7:0] IDX_ERROR = 8'h0a;
    localparam logic [7:0] IDX_CLASH = 8'h0b;
    localparam logic [7:0] IDX_COUNT = 8'h0c;
    localparam logic [7:0] IDX_CRC_LO = 8'h0d;
    // control field positions
    localparam int unsigned CTL_LIGHT = 5;
    localparam int unsigned CTL_DEEP = 4;
    localparam int unsigned CTL_CIPHER = 3;
    localparam int unsigned CTL_HALT = 2;
    localparam int unsigned CTL_LAUNCH = 1;
    localparam int unsigned CTL_FLUSH = 0;
    // error field positions
    localparam int unsigned ERR_KEY = 6;
    localparam int unsigned ERR_NVM = 5;
    localparam int unsigned ERR_OVR = 4;
    localparam int unsigned ERR_CRC = 3;
    localparam int unsigned ERR_SOF = 2;
    localparam int unsigned ERR_PAR = 1;
    localparam int unsigned ERR_CLASH = 0;
    localparam int unsigned ERR_BITS = 7;
    // status field position
    localparam int unsigned STAT_CRC_DONE = 5;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] ERROR_RST = 8'h40;
    localparam logic [7:0] CLASH_RST = 8'h00;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// ---- src/csp_regs.sv ----
// control and status page register bank with ahb-lite slave port
//
// Overview of operation
// - light sleep bit switches blocks off, clock keeps running
// - deep sleep bit switches blocks off and stops the clock
// - cipher enable one encrypts card traffic, zero passes plain data
// - cipher enable set only by successful second auth step
// - writing one to halt strobe stops timer at once
// - writing one to launch strobe starts timer at once
// - flush resets queue pointers, fill count and overrun flag
// - halt, launch and flush bits always read zero
// - error flags show last command status, reset to 40h
// - key format error cleared at key load start, set on bad key
// - nvm permission error cleared at nvm command start, set on violation
// - overrun flag set on any write into full queue
// - checksum error set when checksum check enabled and check fails
// - start of frame error set on bad start of frame
// - bit check error set on parity failure
// - bit clash error set on detected collision
// - four receive error bits cleared in receiver prepare state
// - first clash position holds bit index of first collision
// - countdown value reads the live eight bit timer count
// - checksum low byte readable, valid only while checksum done
// - checksum done reads one when calculation finished
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module csp_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power control
    output logic blocks_off,
    output logic clock_stop,
    // cipher
    input wire logic auth2_success,
    input wire logic plain_bit,
    input wire logic keystream_bit,
    output logic stream_cipher_enable,
    output logic card_bit,
    // timer
    input wire logic [7:0] timer_count,
    output logic timer_halt_strobe,
    output logic timer_launch_strobe,
    // queue
    input wire logic queue_write_full,
    output logic queue_flush,
    // command and receiver events
    input wire logic key_load_start,
    input wire logic key_format_bad,
    input wire logic nvm_cmd_start,
    input wire logic nvm_access_violation,
    input wire logic receiver_prepare_state,
    input wire logic receive_checksum_enable,
    input wire logic rx_checksum_fail,
    input wire logic rx_sof_bad,
    input wire logic rx_parity_fail,
    input wire logic rx_clash,
    input wire logic [7:0] rx_clash_bit,
    // checksum unit
    input wire logic checksum_done,
    input wire logic [7:0] checksum_low_byte
);
    import csp_pkg::*;

    logic take;
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic wr_ctl;
    logic [7:0] rd_mux;
    logic light_sleep_reg;
    logic deep_sleep_reg;
    logic cipher_reg;
    logic [7:0] clash_pos_reg;
    logic [ERR_BITS-1:0] err_set;
    logic [ERR_BITS-1:0] err_clr;
    logic [ERR_BITS-1:0] err_q;
    logic flush_now;

    // address phase accepted when selected, ready and htrans is nonseq or seq (idle and busy are ignored)
    assign take = hsel && hready && htrans[1];
    assign wr_ctl = wr_pend_reg && (wr_idx_reg == IDX_CONTROL);
    assign flush_now = wr_ctl && hwdata[CTL_FLUSH];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take && hwrite;
            wr_idx_reg <= haddr[9:2];
        end
    end

    // zero wait state: ready is always high, response always okay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (haddr[9:2])
            IDX_CONTROL: begin
                rd_mux[CTL_LIGHT] = light_sleep_reg;
                rd_mux[CTL_DEEP] = deep_sleep_reg;
                rd_mux[CTL_CIPHER] = cipher_reg;
            end
            IDX_ERROR: begin
                rd_mux[ERR_BITS-1:0] = err_q;
            end
            IDX_CLASH: begin
                rd_mux = clash_pos_reg;
            end
            IDX_COUNT: begin
                rd_mux = timer_count;
            end
            IDX_CRC_LO: begin
                rd_mux = checksum_low_byte;
            end
            IDX_STATUS: begin
                rd_mux[STAT_CRC_DONE] = checksum_done;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read data sampled in the address phase, held until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= {24'h00_0000, rd_mux};
        end
    end

    // sleep request bits; bits 7 and 6 are not stored at all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            light_sleep_reg <= CONTROL_RST[CTL_LIGHT];
            deep_sleep_reg <= CONTROL_RST[CTL_DEEP];
        end else if (wr_ctl) begin
            light_sleep_reg <= hwdata[CTL_LIGHT];
            deep_sleep_reg <= hwdata[CTL_DEEP];
        end
    end

    // power outputs follow the request bits one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blocks_off <= 1'b0;
            clock_stop <= 1'b0;
        end else begin
            blocks_off <= light_sleep_reg || deep_sleep_reg;
            clock_stop <= deep_sleep_reg;
        end
    end

    // software may only switch the cipher off; auth success wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cipher_reg <= CONTROL_RST[CTL_CIPHER];
        end else if (auth2_success) begin
            cipher_reg <= 1'b1;
        end else if (wr_ctl && !hwdata[CTL_CIPHER]) begin
            cipher_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stream_cipher_enable <= 1'b0;
            card_bit <= 1'b0;
        end else begin
            stream_cipher_enable <= cipher_reg;
            card_bit <= cipher_reg ? (plain_bit ^ keystream_bit) : plain_bit;
        end
    end

    // one-cycle strobes; nothing is stored, so they read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_halt_strobe <= 1'b0;
            timer_launch_strobe <= 1'b0;
            queue_flush <= 1'b0;
        end else begin
            timer_halt_strobe <= wr_ctl && hwdata[CTL_HALT];
            timer_launch_strobe <= wr_ctl && hwdata[CTL_LAUNCH];
            queue_flush <= flush_now;
        end
    end

    // error flag events
    always_comb begin
        err_set = '0;
        err_clr = '0;
        err_set[ERR_KEY] = key_format_bad;
        err_clr[ERR_KEY] = key_load_start;
        err_set[ERR_NVM] = nvm_access_violation;
        err_clr[ERR_NVM] = nvm_cmd_start;
        err_set[ERR_OVR] = queue_write_full;
        err_clr[ERR_OVR] = flush_now;
        err_set[ERR_CRC] = receive_checksum_enable && rx_checksum_fail;
        err_set[ERR_SOF] = rx_sof_bad;
        err_set[ERR_PAR] = rx_parity_fail;
        err_set[ERR_CLASH] = rx_clash;
        err_clr[ERR_CRC] = receiver_prepare_state;
        err_clr[ERR_SOF] = receiver_prepare_state;
        err_clr[ERR_PAR] = receiver_prepare_state;
        err_clr[ERR_CLASH] = receiver_prepare_state;
    end

    genvar gi;
    generate
        for (gi = 0; gi < ERR_BITS; gi++) begin : g_err
            csp_sticky_flag #(
                .RST_VAL(ERROR_RST[gi])
            ) u_flag (
                .clk(clk),
                .rst_n(rst_n),
                .set_evt(err_set[gi]),
                .clr_evt(err_clr[gi]),
                .flag(err_q[gi])
            );
        end
    endgenerate

    // only the first clash of a frame is kept; the flag marks it taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clash_pos_reg <= CLASH_RST;
        end else if (rx_clash && (!err_q[ERR_CLASH] || receiver_prepare_state)) begin
            clash_pos_reg <= rx_clash_bit;
        end
    end

    property p_strobe_read_zero;
        @(posedge clk) disable iff (!rst_n)
        (take && !hwrite && haddr[9:2] == IDX_CONTROL)
            |=> (hrdata[2:0] == 3'b000) && (hrdata[7:6] == 2'b00);
    endproperty
    a_strobe_read_zero: assert property (p_strobe_read_zero)
        else $error("control strobe or reserved bit read nonzero");

    property p_cipher_rise;
        @(posedge clk) disable iff (!rst_n)
        $rose(cipher_reg) |-> $past(auth2_success);
    endproperty
    a_cipher_rise: assert property (p_cipher_rise)
        else $error("cipher enabled without auth success");

    property p_cipher_out;
        @(posedge clk) disable iff (!rst_n)
        cipher_reg |=> stream_cipher_enable
            && (card_bit == ($past(plain_bit) ^ $past(keystream_bit)));
    endproperty
    a_cipher_out: assert property (p_cipher_out)
        else $error("card bit not encrypted while cipher on");

    property p_flush;
        @(posedge clk) disable iff (!rst_n)
        (flush_now && !queue_write_full)
            |=> queue_flush && !err_q[ERR_OVR] ##1 !queue_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush did not pulse or clear overrun");

    property p_launch;
        @(posedge clk) disable iff (!rst_n)
        (wr_ctl && hwdata[CTL_LAUNCH]) |=> timer_launch_strobe;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch strobe missing");

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        timer_halt_strobe |-> $past(wr_ctl) && $past(hwdata[CTL_HALT]);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt strobe without write");

    property p_deep;
        @(posedge clk) disable iff (!rst_n)
        (take && hwrite && haddr[9:2] == IDX_CONTROL) ##1 hwdata[CTL_DEEP]
            |=> ##1 blocks_off && clock_stop;
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep sleep did not stop clock");

    property p_light;
        @(posedge clk) disable iff (!rst_n)
        (light_sleep_reg && !deep_sleep_reg) |=> blocks_off && !clock_stop;
    endproperty
    a_light: assert property (p_light)
        else $error("light sleep wrong power state");

    property p_key;
        @(posedge clk) disable iff (!rst_n)
        (key_load_start && !key_format_bad) |=> !err_q[ERR_KEY];
    endproperty
    a_key: assert property (p_key)
        else $error("key error not cleared at load start");

    property p_overrun;
        @(posedge clk) disable iff (!rst_n)
        queue_write_full |=> err_q[ERR_OVR];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_prepare;
        @(posedge clk) disable iff (!rst_n)
        (receiver_prepare_state && !rx_sof_bad && !rx_parity_fail && !rx_clash
            && !rx_checksum_fail) |=> (err_q[3:0] == 4'h0);
    endproperty
    a_prepare: assert property (p_prepare)
        else $error("receive errors not cleared in prepare");

    property p_err_read;
        @(posedge clk) disable iff (!rst_n)
        (take && !hwrite && haddr[9:2] == IDX_ERROR)
            |=> hrdata == {25'h0, $past(err_q)};
    endproperty
    a_err_read: assert property (p_err_read)
        else $error("error register read mismatch");

endmodule // csp_regs

// ---- src/csp_sticky_flag.sv ----
// one error flag: hardware set beats clear
`timescale 1ns/1ns
module csp_sticky_flag #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events
    input wire logic set_evt,
    input wire logic clr_evt,
    // state
    output logic flag
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= RST_VAL;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_evt) begin
            flag <= 1'b0;
        end
    end
endmodule // csp_sticky_flag

// ---- testbench/csp_regs_test.sv ----
// self-checking bench for the control and status page register bank
`timescale 1ns/1ns
module csp_regs_test;
    import csp_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hresp, blocks_off, clock_stop, stream_cipher_enable, card_bit;
    logic [31:0] hrdata;
    logic timer_halt_strobe, timer_launch_strobe, queue_flush;
    logic plain_bit = 1'b0;
    logic keystream_bit = 1'b0;
    logic receive_checksum_enable = 1'b0;
    logic checksum_done = 1'b0;
    logic [7:0] timer_count = 8'h00;
    logic [7:0] checksum_low_byte = 8'h00;
    logic [7:0] rx_clash_bit = 8'h00;
    logic [9:0] ev = 10'h0;
    logic clash_evt = 1'b0;
    logic [31:0] rd;
    int errors = 0;
    int n_compared = 0;
    int sc [3] = '{0, 0, 0};

    always #5 clk = ~clk;

    csp_regs u_csp_regs (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .blocks_off(blocks_off), .clock_stop(clock_stop),
        .auth2_success(ev[0]), .plain_bit(plain_bit), .keystream_bit(keystream_bit),
        .stream_cipher_enable(stream_cipher_enable), .card_bit(card_bit),
        .timer_count(timer_count), .timer_halt_strobe(timer_halt_strobe),
        .timer_launch_strobe(timer_launch_strobe), .queue_write_full(ev[1]),
        .queue_flush(queue_flush), .key_load_start(ev[2]), .key_format_bad(ev[3]),
        .nvm_cmd_start(ev[4]), .nvm_access_violation(ev[5]),
        .receiver_prepare_state(ev[6]), .receive_checksum_enable(receive_checksum_enable),
        .rx_checksum_fail(ev[7]), .rx_sof_bad(ev[8]), .rx_parity_fail(ev[9]),
        .rx_clash(clash_evt), .rx_clash_bit(rx_clash_bit),
        .checksum_done(checksum_done), .checksum_low_byte(checksum_low_byte)
    );

    // strobes are one-cycle pulses, so counting high cycles shows their width
    always @(posedge clk) begin
        if (timer_halt_strobe === 1'b1) sc[0]++;
        if (timer_launch_strobe === 1'b1) sc[1]++;
        if (queue_flush === 1'b1) sc[2]++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask

    task automatic bus_read(input logic [7:0] idx, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask

    task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
        bus_read(idx, rd);
        check(rd, {24'h0, exp});
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    // index 10 drives the clash event, the rest come straight from ev
    task automatic pulse(input int k);
        if (k == 10) clash_evt <= 1'b1;
        else ev[k] <= 1'b1;
        @(posedge clk);
        if (k == 10) clash_evt <= 1'b0;
        else ev[k] <= 1'b0;
        @(posedge clk);
    endtask

    // sample registered outputs after the edge has landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        read_check(IDX_ERROR, 8'h40);
        read_check(IDX_CONTROL, 8'h00);
        read_check(IDX_CLASH, 8'h00);
        timer_count <= 8'h5a;
        checksum_low_byte <= 8'hc3;
        checksum_done <= 1'b1;
        read_check(IDX_COUNT, 8'h5a);
        read_check(IDX_CRC_LO, 8'hc3);
        read_check(IDX_STATUS, 8'h20);
        checksum_done <= 1'b0;
        read_check(IDX_STATUS, 8'h00);
        read_check(8'h20, 8'h00);
        $display("test reset and read-only values done");

        // all bits written as one: software cannot switch the cipher on
        bus_write(IDX_CONTROL, 8'hff);
        settle(3);
        check(sc[0], 1);
        check(sc[1], 1);
        check(sc[2], 1);
        check(blocks_off, 1'b1);
        check(clock_stop, 1'b1);
        check(stream_cipher_enable, 1'b0);
        @(posedge clk);
        read_check(IDX_CONTROL, 8'h30);
        bus_write(IDX_CONTROL, 8'h24);
        settle(3);
        check(sc[0], 2);
        check(sc[1], 1);
        check(blocks_off, 1'b1);
        check(clock_stop, 1'b0);
        @(posedge clk);
        read_check(IDX_CONTROL, 8'h20);
        bus_write(IDX_CONTROL, 8'h00);
        settle(3);
        check(blocks_off, 1'b0);
        @(posedge clk);
        $display("test control strobes and sleep done");

        plain_bit <= 1'b1;
        keystream_bit <= 1'b1;
        settle(3);
        check(card_bit, 1'b1);
        @(posedge clk);
        pulse(0);
        settle(3);
        check(stream_cipher_enable, 1'b1);
        check(card_bit, 1'b0);
        @(posedge clk);
        read_check(IDX_CONTROL, 8'h08);
        bus_write(IDX_CONTROL, 8'h00);
        read_check(IDX_CONTROL, 8'h00);
        $display("test cipher enable done");

        bus_write(IDX_ERROR, 8'hbf);
        read_check(IDX_ERROR, 8'h40);
        pulse(2);
        read_check(IDX_ERROR, 8'h00);
        pulse(3);
        read_check(IDX_ERROR, 8'h40);
        pulse(5);
        read_check(IDX_ERROR, 8'h60);
        pulse(4);
        read_check(IDX_ERROR, 8'h40);
        pulse(1);
        read_check(IDX_ERROR, 8'h50);
        bus_write(IDX_CONTROL, 8'h01);
        read_check(IDX_ERROR, 8'h40);
        pulse(7);
        read_check(IDX_ERROR, 8'h40);
        receive_checksum_enable <= 1'b1;
        pulse(7);
        read_check(IDX_ERROR, 8'h48);
        pulse(8);
        read_check(IDX_ERROR, 8'h4c);
        pulse(9);
        read_check(IDX_ERROR, 8'h4e);
        rx_clash_bit <= 8'h08;
        pulse(10);
        read_check(IDX_ERROR, 8'h4f);
        read_check(IDX_CLASH, 8'h08);
        rx_clash_bit <= 8'h03;
        pulse(10);
        read_check(IDX_CLASH, 8'h08);
        pulse(6);
        read_check(IDX_ERROR, 8'h40);
        rx_clash_bit <= 8'h01;
        pulse(10);
        read_check(IDX_CLASH, 8'h01);
        $display("test error flags done");
        tally_and_finish();
    end
endmodule // csp_regs_test
